// ===== hw/uab_defines.svh
`ifndef UAB_DEFINES_SVH
`define UAB_DEFINES_SVH
// ==========================================================
// Register offsets (byte addresses, one 8-bit register each)
// ==========================================================
`define UAB_OFS_BAUD_CTRL  8'h00
`define UAB_OFS_MODE       8'h04
`define UAB_OFS_DIV_LOW    8'h08
`define UAB_OFS_DIV_HIGH   8'h0C
`define UAB_OFS_RX_BUF     8'h10
`define UAB_OFS_TX_BUF     8'h14
`define UAB_OFS_IRQ_STAT   8'h18
`define UAB_OFS_IRQ_MASK   8'h1C
// ==========================================================
// Field positions
// ==========================================================
`define UAB_BIT_AUTOBAUD_ENABLE      0
`define UAB_BIT_WOB        1
`define UAB_BIT_WIDE       3
`define UAB_BIT_OVF        7
`define UAB_BIT_SYNC       0
`define UAB_BIT_HS         2
`define UAB_IRQ_DONE       0
`define UAB_IRQ_OVF        1
`define UAB_IRQ_RDY        2
// ==========================================================
// Reset values
// ==========================================================
`define UAB_RST_BYTE       8'h00
`define UAB_RST_DIV        16'h0000
`define UAB_RX_BUF_VALUE   8'h00
// ==========================================================
// Timing counts: counter clock dividers, minus one
// ==========================================================
`define UAB_LIM_DIV512     9'h1FF
`define UAB_LIM_DIV128     9'h07F
`define UAB_LIM_DIV32      9'h01F
`define UAB_SLOWDOWN_SHIFT 3
`define UAB_EDGE_LAST      3'h4
`endif

// ===== hw/uab_pkg.sv
package uab_pkg;
  // ========================================================
  // Measurement sequencer states
  // ========================================================
  typedef enum logic [2:0]
  {
    ST_IDLE     = 3'h0,
    ST_BRK_LOW  = 3'h1,
    ST_BRK_HIGH = 3'h2,
    ST_START    = 3'h3,
    ST_ARM      = 3'h4,
    ST_COUNT    = 3'h5
  } uab_state_t;
endpackage : uab_pkg

// ===== hw/uab_pin_sync.sv
`timescale 1ns/10ps
// ==========================================================
// Three-stage pin synchroniser with agreement filter
// ==========================================================
module uab_pin_sync
(
  input  wire logic i_ref_clk,
  input  wire logic i_rst_n,
  input  wire logic i_pin,
  output logic      o_level
);
  logic s1_r;  // First stage, read only by s2
  logic s2_r;  // Second stage
  logic s3_r;  // Third stage
  // Shift chain; idle line is high
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s1_r    <= 1'b1;
      s2_r    <= 1'b1;
      s3_r    <= 1'b1;
      o_level <= 1'b1;
    end
    else
    begin
      s1_r <= i_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // Level moves only when the last two stages agree
      if (s2_r == s3_r)
        o_level <= s3_r;
    end
  end
endmodule : uab_pin_sync

// ===== hw/uab_autobaud.sv
`timescale 1ns/10ps
`include "uab_defines.svh"
// Overview of operation
// (R1) Measure only in async mode, wake-break clear
// (R2) Start on start bit once enable set
// (R3) Generator becomes counter timed by edges
// (R4) Setting enable clears counter, awaits start
// (R5) Remote sends 0x55 calibration byte
// (R6) Count from first rising edge into divisor
// (R7) Fifth edge clears enable automatically
// (R8) Counter wrap sets overflow flag bit 7
// (R9) Rollover keeps mode and enable set
// (R10) Counter clock is one eighth normal
// (R11) Divisor pair always one 16-bit counter
// (R12) Counter clock Fosc/512, /128, /32
// (R13) Receive state machine held idle meanwhile
// (R14) Fifth rising edge sets ready; read clears
// (R15) With wake-break set, measure following byte
// (R16) No transmit buffer writes while enabled
// (R17) Do not enable during transmission
// (R18) Software checks rate is measurable
// (R19) After done, resume generation from divisor
module uab_autobaud
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_n,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic       i_rx,
  output logic      [7:0] o_rdata,
  output logic            o_irq,
  output logic            o_baud_tick,
  output logic            o_rx_hold,
  output logic            o_tx_load,
  output logic      [7:0] o_tx_data
);
  // ========================================================
  // Registers and state
  // ========================================================
  logic              autobaud_enable_r;    // autobaud_enable
  logic              wob_r;      // wake_on_break_enable
  logic              wide_r;     // wide_divisor_select
  logic              ovf_r;      // autobaud_overflow_flag
  logic              sync_r;     // Synchronous mode select
  logic              hs_r;       // high_speed_select
  logic [15:0]       div_r;      // baud_divisor_high:low
  logic              rdy_r;      // receive_ready_flag
  logic [2:0]        stat_r;     // Sticky interrupt status
  logic [2:0]        mask_r;     // Interrupt mask
  logic [8:0]        ps_r;       // Prescaler
  logic [15:0]       gen_r;      // Normal generator count
  logic [2:0]        edges_r;    // Rising edges after first
  logic              rx_d_r;     // Delayed filtered line
  uab_pkg::uab_state_t state_r;  // Sequencer state
  uab_pkg::uab_state_t state_nxt;
  logic              rx_lvl;     // Filtered receive line
  // ========================================================
  // Receive pin synchroniser
  // ========================================================
  uab_pin_sync u_rx_sync
  (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_pin     (i_rx),
    .o_level   (rx_lvl)
  );
  // ========================================================
  // Decode
  // ========================================================
  wire wr_ctrl  = i_wr && (i_addr == `UAB_OFS_BAUD_CTRL);
  wire wr_mode  = i_wr && (i_addr == `UAB_OFS_MODE);
  wire wr_divlo = i_wr && (i_addr == `UAB_OFS_DIV_LOW);
  wire wr_divhi = i_wr && (i_addr == `UAB_OFS_DIV_HIGH);
  wire wr_tx    = i_wr && (i_addr == `UAB_OFS_TX_BUF);
  wire wr_stat  = i_wr && (i_addr == `UAB_OFS_IRQ_STAT);
  wire wr_mask  = i_wr && (i_addr == `UAB_OFS_IRQ_MASK);
  wire rd_rxbuf = i_rd && (i_addr == `UAB_OFS_RX_BUF);
  // Enable goes from clear to set by software
  wire arm      = wr_ctrl && i_wdata[`UAB_BIT_AUTOBAUD_ENABLE] && !autobaud_enable_r;
  wire rise     = rx_lvl && !rx_d_r;
  wire fall     = !rx_lvl && rx_d_r;
  wire counting = (state_r == uab_pkg::ST_COUNT);
  wire active   = (state_r != uab_pkg::ST_IDLE);
  // Counter clock select by the two divisor bits
  wire [8:0] lim_cnt = (wide_r && hs_r) ? `UAB_LIM_DIV32 :
                       (wide_r || hs_r) ? `UAB_LIM_DIV128 :
                                          `UAB_LIM_DIV512;      // R12
  // Normal rate is eight times the counter clock
  wire [8:0] lim_gen = lim_cnt >> `UAB_SLOWDOWN_SHIFT;        // R10
  wire [8:0] lim     = active ? lim_cnt : lim_gen;
  wire       ps_tick = (ps_r == lim);
  wire       cnt_tick = counting && ps_tick;                  // R3
  wire       wrap     = cnt_tick && (div_r == 16'hFFFF);      // R8 R9
  wire       last     = counting && rise &&
                        (edges_r == `UAB_EDGE_LAST - 3'h1);   // R7
  // Narrow divisor in 8-bit mode for normal generation
  wire [15:0] gen_lim = wide_r ? div_r : {8'h00, div_r[7:0]};
  wire        gen_run = !active && !autobaud_enable_r && !sync_r && !arm; // R19
  wire        gen_hit = gen_run && ps_tick && (gen_r == gen_lim);
  // Hardware events for sticky status
  wire [2:0] ev;
  assign ev[`UAB_IRQ_DONE] = last;
  assign ev[`UAB_IRQ_OVF]  = wrap;
  assign ev[`UAB_IRQ_RDY]  = last;
  // ========================================================
  // Sequencer next state
  // ========================================================
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      uab_pkg::ST_IDLE:
        if (arm && !sync_r)
          state_nxt = (wob_r || i_wdata[`UAB_BIT_WOB]) ?
                      uab_pkg::ST_BRK_LOW : uab_pkg::ST_START; // R4
      uab_pkg::ST_BRK_LOW:
        if (!rx_lvl)
          state_nxt = uab_pkg::ST_BRK_HIGH;                    // R15
      uab_pkg::ST_BRK_HIGH:
        if (rx_lvl)
          state_nxt = uab_pkg::ST_START;                       // R15
      uab_pkg::ST_START:
        if (fall && !wob_r)
          state_nxt = uab_pkg::ST_ARM;                         // R2
      uab_pkg::ST_ARM:
        if (rise)
          state_nxt = uab_pkg::ST_COUNT;                       // R6
      uab_pkg::ST_COUNT:
        if (last)
          state_nxt = uab_pkg::ST_IDLE;                        // R7
      default:
        state_nxt = uab_pkg::ST_IDLE;
    endcase
    // Synchronous mode or software clearing enable aborts
    if (sync_r || (active && !autobaud_enable_r))
      state_nxt = uab_pkg::ST_IDLE;                            // R1
  end
  // ========================================================
  // Sequencer, prescaler and edge tracking
  // ========================================================
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_r <= uab_pkg::ST_IDLE;
      rx_d_r  <= 1'b1;
      edges_r <= 3'h0;
      ps_r    <= 9'h000;
    end
    else
    begin
      state_r <= state_nxt;
      rx_d_r  <= rx_lvl;
      // Edge count restarts at the first rising edge
      if (state_r != uab_pkg::ST_COUNT)
        edges_r <= 3'h0;
      else if (rise)
        edges_r <= edges_r + 3'h1;
      // Prescaler restarts when counting begins
      if (state_r == uab_pkg::ST_ARM || ps_tick)
        ps_r <= 9'h000;
      else
        ps_r <= ps_r + 9'h001;
    end
  end
  // ========================================================
  // Control register: enable, wake-break, width, overflow
  // ========================================================
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      autobaud_enable_r <= 1'b0;
      wob_r   <= 1'b0;
      wide_r  <= 1'b0;
      ovf_r   <= 1'b0;
      sync_r  <= 1'b0;
      hs_r    <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        autobaud_enable_r <= i_wdata[`UAB_BIT_AUTOBAUD_ENABLE];
        wob_r   <= i_wdata[`UAB_BIT_WOB];
        wide_r  <= i_wdata[`UAB_BIT_WIDE];
        ovf_r   <= i_wdata[`UAB_BIT_OVF];
      end
      // Break over: wake phase ends, measurement may run
      if (state_r == uab_pkg::ST_BRK_HIGH && rx_lvl)
        wob_r <= 1'b0;                                         // R15
      // Auto-clear on the fifth edge beats a software write
      if (last)
        autobaud_enable_r <= 1'b0;                                       // R7
      // Wrap sets the flag; set wins over software clear
      if (wrap)
        ovf_r <= 1'b1;                                         // R8
      if (wr_mode)
      begin
        sync_r <= i_wdata[`UAB_BIT_SYNC];
        hs_r   <= i_wdata[`UAB_BIT_HS];
      end
    end
  end
  // ========================================================
  // Divisor pair: software value or measurement counter
  // ========================================================
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      div_r <= `UAB_RST_DIV;
    else if (arm && !sync_r)
      div_r <= 16'h0000;                                       // R4
    else if (cnt_tick)
      div_r <= div_r + 16'h0001;                               // R11
    else if (!active)
    begin
      if (wr_divlo)
        div_r[7:0] <= i_wdata;
      if (wr_divhi)
        div_r[15:8] <= i_wdata;
    end
  end
  // ========================================================
  // Normal baud generation from the kept divisor
  // ========================================================
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      gen_r       <= 16'h0000;
      o_baud_tick <= 1'b0;
    end
    else
    begin
      if (!gen_run || gen_hit)
        gen_r <= 16'h0000;
      else if (ps_tick)
        gen_r <= gen_r + 16'h0001;
      o_baud_tick <= gen_hit;                                  // R19
    end
  end
  // ========================================================
  // Ready flag, status, mask and interrupt
  // ========================================================
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rdy_r  <= 1'b0;
      stat_r <= 3'h0;
      mask_r <= 3'h0;
      o_irq  <= 1'b0;
    end
    else
    begin
      // Reading the receive buffer clears; a new set wins
      rdy_r <= last || (rdy_r && !rd_rxbuf);                   // R14
      // Write one to clear; events win
      stat_r <= ev | (stat_r & ~(wr_stat ? i_wdata[2:0] : 3'h0));
      if (wr_mask)
        mask_r <= i_wdata[2:0];
      o_irq <= |(stat_r & mask_r);
    end
  end
  // ========================================================
  // Receiver hold and transmit buffer gate
  // ========================================================
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_rx_hold <= 1'b0;
      o_tx_load <= 1'b0;
      o_tx_data <= `UAB_RST_BYTE;
    end
    else
    begin
      o_rx_hold <= (state_nxt != uab_pkg::ST_IDLE);            // R13
      // Writes while enabled are dropped
      o_tx_load <= wr_tx && !autobaud_enable_r;                          // R16
      if (wr_tx && !autobaud_enable_r)
        o_tx_data <= i_wdata;
    end
  end
  // ========================================================
  // Read data, one cycle after the strobe
  // ========================================================
  logic [7:0] rd_mux;
  always_comb
  begin
    rd_mux = 8'h00;
    case (i_addr)
      `UAB_OFS_BAUD_CTRL:
        rd_mux = {ovf_r, 3'h0, wide_r, 1'b0, wob_r, autobaud_enable_r};
      `UAB_OFS_MODE:
        rd_mux = {5'h00, hs_r, 1'b0, sync_r};
      `UAB_OFS_DIV_LOW:  rd_mux = div_r[7:0];
      `UAB_OFS_DIV_HIGH: rd_mux = div_r[15:8];
      `UAB_OFS_RX_BUF:   rd_mux = `UAB_RX_BUF_VALUE;
      `UAB_OFS_IRQ_STAT: rd_mux = {5'h00, stat_r};
      `UAB_OFS_IRQ_MASK: rd_mux = {5'h00, mask_r};
      default:           rd_mux = 8'h00;
    endcase
  end
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_rdata <= 8'h00;
    else
      o_rdata <= i_rd ? rd_mux : 8'h00;
  end
  // ========================================================
  // Checks
  // ========================================================
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  chk_abd_async_only: assert property ( // R1
    (sync_r && active) |=> state_r == uab_pkg::ST_IDLE)
    else $error("measurement continued in sync mode");
  chk_no_wob_count: assert property ( // R1
    (state_r == uab_pkg::ST_ARM || counting) |-> !wob_r)
    else $error("counting with wake-on-break set");
  chk_arm_clears: assert property ( // R4
    (arm && !sync_r && state_r == uab_pkg::ST_IDLE)
    |=> div_r == 16'h0000 && active)
    else $error("arming did not clear counter");
  chk_fifth_edge: assert property ( // R7
    last |=> !autobaud_enable_r && rdy_r && state_r == uab_pkg::ST_IDLE)
    else $error("fifth edge did not finish");
  chk_ovf_wrap: assert property ( // R8
    wrap |=> ovf_r && div_r == 16'h0000 && autobaud_enable_r && counting)
    else $error("rollover not trapped");
  chk_count_rate: assert property ( // R12
    cnt_tick |-> ps_r == lim_cnt && $past(ps_r) == lim_cnt - 9'h001)
    else $error("counter clock rate wrong");
  chk_rx_hold: assert property ( // R13
    active |-> o_rx_hold)
    else $error("receiver not held");
  chk_tx_block: assert property ( // R16
    (wr_tx && autobaud_enable_r) |=> !o_tx_load)
    else $error("transmit load while enabled");
  chk_no_gen_tick: assert property ( // R3
    autobaud_enable_r |=> !o_baud_tick)
    else $error("bit timing during measurement");
  chk_rdy_clear: assert property ( // R14
    (rd_rxbuf && !last) |=> !rdy_r)
    else $error("ready not cleared by read");
endmodule : uab_autobaud

// ===== verification/uab_serial_src.sv
`timescale 1ns/10ps
// ==========================================================
// Remote transmitter: frames bytes onto the receive line
// ==========================================================
module uab_serial_src
(
  input  wire logic i_ref_clk,
  output logic      o_rx
);
  // Line idles high between frames
  initial o_rx = 1'b1;

  // Hold one line level for a number of clock cycles
  task automatic hold_lvl(input logic lvl, input int cyc);
    o_rx <= lvl;
    repeat (cyc) @(posedge i_ref_clk);
  endtask : hold_lvl

  // Optional break, then start, eight data bits LSB first, stop
  task automatic send(input logic [7:0] data, input int bit_cyc,
                      input bit brk);
    @(posedge i_ref_clk);
    if (brk)
    begin
      hold_lvl(1'b0, 13 * bit_cyc);
      hold_lvl(1'b1, 2 * bit_cyc);
    end
    hold_lvl(1'b0, bit_cyc);
    for (int i = 0; i < 8; i++)
      hold_lvl(data[i], bit_cyc);
    hold_lvl(1'b1, 2 * bit_cyc);
  endtask : send
endmodule : uab_serial_src

// ===== verification/test_uab_autobaud.sv
`timescale 1ns/10ps
`include "uab_defines.svh"
// ==========================================================
// Bench for the autobaud block
// ==========================================================
module test_uab_autobaud;
  // One measurement case: setup bytes, bit time, expected count
  typedef struct
  {
    logic [7:0]  mode;
    logic [7:0]  ctrl;
    int          bit_cyc;
    bit          brk;
    logic [15:0] div;
  } uab_row_t;

  logic        i_ref_clk  = 1'b0;
  logic        i_rst_n    = 1'b0;
  logic [7:0]  i_addr     = 8'h00;
  logic [7:0]  i_wdata    = 8'h00;
  logic        i_wr       = 1'b0;
  logic        i_rd       = 1'b0;
  wire         i_rx;
  logic [7:0]  o_rdata;
  logic        o_irq;
  logic        o_baud_tick;
  logic        o_rx_hold;
  logic        o_tx_load;
  logic [7:0]  o_tx_data;
  int          n_mismatch = 0;
  int          cmp_count  = 0;
  int          tx_cnt     = 0;
  int          hold_ticks = 0;
  int          ticks      = 0;

  // Rates chosen inside the measurable span of each clock
  uab_row_t rows [5] = '{
    '{8'h00, 8'h01, 1024, 1'b0, 16'h0010},
    '{8'h04, 8'h01, 2048, 1'b0, 16'h0080},
    '{8'h00, 8'h09, 1024, 1'b0, 16'h0040},
    '{8'h04, 8'h09, 1024, 1'b0, 16'h0100},
    '{8'h04, 8'h0B, 128,  1'b1, 16'h0020}
  };

  // Clock at 200 MHz
  always #2.5 i_ref_clk = ~i_ref_clk;

  uab_autobaud dut
  (
    .i_ref_clk   (i_ref_clk),
    .i_rst_n     (i_rst_n),
    .i_addr      (i_addr),
    .i_wdata     (i_wdata),
    .i_wr        (i_wr),
    .i_rd        (i_rd),
    .i_rx        (i_rx),
    .o_rdata     (o_rdata),
    .o_irq       (o_irq),
    .o_baud_tick (o_baud_tick),
    .o_rx_hold   (o_rx_hold),
    .o_tx_load   (o_tx_load),
    .o_tx_data   (o_tx_data)
  );

  uab_serial_src src
  (
    .i_ref_clk (i_ref_clk),
    .o_rx      (i_rx)
  );

  // Count load pulses and generator ticks
  always @(posedge i_ref_clk)
  begin
    if (o_tx_load === 1'b1)
      tx_cnt++;
    if (o_baud_tick === 1'b1)
      ticks++;
    if (o_baud_tick === 1'b1 && o_rx_hold === 1'b1)
      hold_ticks++;
  end

  // ========================================================
  // Helpers
  // ========================================================
  task automatic results;
    $display("mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // True when a count lies within one of the expected value
  function automatic logic near(input logic [15:0] s,
                                input logic [15:0] e);
    return (s + 16'h0001 >= e) && (s <= e + 16'h0001);
  endfunction : near

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr    <= 1'b0;
  endtask : wr

  // Read data stands in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_ref_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd   <= 1'b0;
    #1 d = o_rdata;
  endtask : rd

  task automatic rdc(input string name, input logic [7:0] a,
                     input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    check(name, {8'h00, d}, {8'h00, e});
  endtask : rdc

  task automatic flag(input string name, input logic e);
    @(posedge i_ref_clk);
    #1 check(name, {15'h0000, o_irq}, {15'h0000, e});
  endtask : flag

  // One full measurement, then interrupt handling
  task automatic measure(input uab_row_t r);
    logic [7:0] lo;
    logic [7:0] hi;
    int         mid;
    mid = (r.brk ? 33 : 7) * r.bit_cyc / 2;
    wr(`UAB_OFS_MODE, r.mode);
    wr(`UAB_OFS_BAUD_CTRL, r.ctrl);
    rdc("div_cleared", `UAB_OFS_DIV_LOW, 8'h00);
    fork
      src.send(8'h55, r.bit_cyc, r.brk);
      begin
        repeat (mid) @(posedge i_ref_clk);
        check("hold", {15'h0000, o_rx_hold}, 16'h0001);
        wr(`UAB_OFS_TX_BUF, 8'h3C);
      end
    join
    repeat (2000)
      if (o_rx_hold === 1'b1)
        @(posedge i_ref_clk);
    if (o_rx_hold !== 1'b0)
    begin
      n_mismatch++;
      results();
    end
    rdc("ctrl_done", `UAB_OFS_BAUD_CTRL, r.ctrl & 8'h08);
    rd(`UAB_OFS_DIV_LOW, lo);
    rd(`UAB_OFS_DIV_HIGH, hi);
    check("div", {15'h0000, near({hi, lo}, r.div)}, 16'h0001);
    check("tx_refused", 16'(tx_cnt), 16'h0000);
    check("irq_done", {15'h0000, o_irq}, 16'h0001);
    rdc("irq_stat", `UAB_OFS_IRQ_STAT, 8'h05);
    rdc("rx_buf", `UAB_OFS_RX_BUF, 8'h00);
    wr(`UAB_OFS_IRQ_MASK, 8'h00);
    flag("irq_masked", 1'b0);
    wr(`UAB_OFS_IRQ_MASK, 8'h07);
    flag("irq_unmasked", 1'b1);
    wr(`UAB_OFS_IRQ_STAT, 8'h07);
    flag("irq_cleared", 1'b0);
  endtask : measure

  // Cut a hang short
  initial
  begin
    repeat (95000) @(posedge i_ref_clk);
    n_mismatch++;
    results();
  end

  // ========================================================
  // Main sequence
  // ========================================================
  initial
  begin
    int t0;
    repeat (20) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    for (int a = 0; a < 8; a++)
      rdc("reset_value", 8'(a * 4), 8'h00);
    rdc("unmapped", 8'h20, 8'h00);
    wr(`UAB_OFS_BAUD_CTRL, 8'h80);
    rdc("ovf_set", `UAB_OFS_BAUD_CTRL, 8'h80);
    wr(`UAB_OFS_BAUD_CTRL, 8'h00);
    rdc("ovf_clear", `UAB_OFS_BAUD_CTRL, 8'h00);
    wr(`UAB_OFS_IRQ_MASK, 8'h07);
    // Each divider setting, then one with a leading break
    foreach (rows[i])
      measure(rows[i]);
    // Synchronous mode must not start a measurement
    wr(`UAB_OFS_MODE, 8'h05);
    wr(`UAB_OFS_BAUD_CTRL, 8'h09);
    fork
      src.send(8'h55, 128, 1'b0);
      begin
        repeat (448) @(posedge i_ref_clk);
        check("sync_hold", {15'h0000, o_rx_hold}, 16'h0000);
      end
    join
    // Normal generation from a divisor: 4 * 32 cycles a tick
    wr(`UAB_OFS_MODE, 8'h04);
    wr(`UAB_OFS_BAUD_CTRL, 8'h08);
    wr(`UAB_OFS_DIV_LOW, 8'h1F);
    wr(`UAB_OFS_DIV_HIGH, 8'h00);
    t0 = ticks;
    repeat (1280) @(posedge i_ref_clk);
    check("ticks", {15'h0000, near(16'(ticks - t0), 16'h000A)},
          16'h0001);
    wr(`UAB_OFS_TX_BUF, 8'hA5);
    @(posedge i_ref_clk);
    #1 check("tx_load", 16'(tx_cnt), 16'h0001);
    check("tx_data", {8'h00, o_tx_data}, 16'h00A5);
    // Clearing the enable by software abandons a measurement
    wr(`UAB_OFS_BAUD_CTRL, 8'h09);
    wr(`UAB_OFS_BAUD_CTRL, 8'h08);
    @(posedge i_ref_clk);
    #1 check("abort_hold", {15'h0000, o_rx_hold}, 16'h0000);
    // Reset in mid-frame leaves the block idle and disarmed
    wr(`UAB_OFS_BAUD_CTRL, 8'h09);
    fork
      src.send(8'h55, 128, 1'b0);
      begin
        repeat (448) @(posedge i_ref_clk);
        check("pre_rst_hold", {15'h0000, o_rx_hold}, 16'h0001);
        i_rst_n <= 1'b0;
        repeat (4) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        @(posedge i_ref_clk);
        #1 check("rst_hold", {15'h0000, o_rx_hold}, 16'h0000);
      end
    join
    rdc("rst_ctrl", `UAB_OFS_BAUD_CTRL, 8'h00);
    check("hold_ticks", 16'(hold_ticks), 16'h0000);
    results();
  end
endmodule : test_uab_autobaud
